// ===== rtl/pfm_pkg.sv
// package: register map, reset values and pin positions of the pin function mux
package pfm_pkg;

    localparam int          PFM_WIDTH           = 8;
    localparam int          PFM_ADDR_WIDTH      = 16;

    // register addresses
    localparam logic [15:0] PFM_ADDR_DATA       = 16'hFFD6;
    localparam logic [15:0] PFM_ADDR_DIRECTION  = 16'hFFE6;
    localparam logic [15:0] PFM_ADDR_PULLUP     = 16'hFFE1;
    localparam logic [15:0] PFM_ADDR_FUNCTION   = 16'hFFCA;

    // reset values and fixed read values
    localparam logic [7:0]  PFM_RST_DATA        = 8'h00;
    localparam logic [7:0]  PFM_RST_DIRECTION   = 8'h00;
    localparam logic [7:0]  PFM_RST_PULLUP      = 8'h00;
    localparam logic [7:0]  PFM_RST_FUNCTION    = 8'h00;
    localparam logic [7:0]  PFM_RD_DIRECTION    = 8'hFF;
    localparam logic [7:0]  PFM_RD_UNMAPPED     = 8'h00;

    // pin and function select bit positions
    localparam int          PFM_PIN_SERIAL_A_CLK = 0;
    localparam int          PFM_PIN_SERIAL_A_DI  = 1;
    localparam int          PFM_PIN_SERIAL_A_DO  = 2;
    localparam int          PFM_PIN_SERIAL_B_CLK = 3;
    localparam int          PFM_PIN_SERIAL_B_DI  = 4;
    localparam int          PFM_PIN_SERIAL_B_DO  = 5;
    localparam int          PFM_PIN_STROBE       = 6;
    localparam int          PFM_PIN_CHIP_SEL     = 7;

    // serial b clock select value that makes its clock pin an input
    localparam logic [2:0]  PFM_CLKSEL_EXTERNAL = 3'h7;

endpackage : pfm_pkg

// ===== rtl/pfm_pin_sync.sv
// file: three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module pfm_pin_sync
#(
    parameter int WIDTH = 8
)
(
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    // raw pins and filtered result
    input  wire logic [WIDTH-1:0] i_pin,
    output logic      [WIDTH-1:0] o_level
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;
    logic [WIDTH-1:0] level_reg;
    logic [WIDTH-1:0] agree;
    logic [WIDTH-1:0] level_next;

    // stage1 feeds only stage2; the filter looks at stages two and three
    assign agree      = ~(stage2_reg ^ stage3_reg);
    assign level_next = (agree & stage2_reg) | (~agree & level_reg);
    assign o_level    = level_reg;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
            level_reg  <= '0;
        end
        else
        begin
            stage1_reg <= i_pin;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            level_reg  <= level_next;
        end
    end

endmodule : pfm_pin_sync

// ===== rtl/pfm_pin_function_mux.sv
// file: pin function select, direction, data and pull-up logic of an 8-pin port
//
// Functional notes
// - input pin (direction 0) gets pull-up exactly when its pull-up bit is 1
// - pull-up register is 8 bits read/write, reset to all zeros
// - function select register is 8 bits read/write, reset to all zeros
// - select bit 7: pin 7 general I/O, or active-low chip-select input
// - select bit 6: pin 6 general I/O, or driven as strobe output
// - select bit 5: pin 5 general I/O, or serial b data output
// - select bit 4: pin 4 general I/O, or serial b data input
// - select bit 3: pin 3 general I/O, or serial b two-way clock
// - select bit 2: pin 2 general I/O, or serial a data output
// - select bit 1: pin 1 general I/O, or serial a data input
// - select bit 0: pin 0 general I/O, or serial a two-way clock
// - direction bit sets the pin drive only while the pin's select bit is 0; pull-up and port read use it always
// - direction 1 means output, 0 input; direction reads back all ones
// - port read gives stored data for outputs, live pin level for inputs
// - serial b clock pin is input when its clock select is 111, else output
// - serial a clock pin is output when clock source is 0, input when 1
`timescale 1ns/1ps

module pfm_pin_function_mux
    import pfm_pkg::*;
#(
    parameter int WIDTH = PFM_WIDTH
)
(
    // clock and reset
    input  wire logic                      i_clk,
    input  wire logic                      i_rst_n,
    // register port
    input  wire logic [PFM_ADDR_WIDTH-1:0] i_addr,
    input  wire logic [7:0]                i_wr_data,
    input  wire logic                      i_wr_en,
    input  wire logic                      i_rd_en,
    output logic      [7:0]                o_rd_data,
    // pads
    input  wire logic [7:0]                i_pad_in,
    output logic      [7:0]                o_pad_out,
    output logic      [7:0]                o_pad_oe_n,
    output logic      [7:0]                o_pad_pullup,
    // serial channel configuration
    input  wire logic [2:0]                i_serial_b_clock_select,
    input  wire logic                      i_serial_a_clock_source,
    // on-chip functions driving pins
    input  wire logic                      i_strobe_out,
    input  wire logic                      i_serial_b_data_out,
    input  wire logic                      i_serial_b_clock_out,
    input  wire logic                      i_serial_a_data_out,
    input  wire logic                      i_serial_a_clock_out,
    // pins delivered to on-chip functions
    output logic                           o_chip_select_n,
    output logic                           o_serial_b_data_in,
    output logic                           o_serial_b_clock_in,
    output logic                           o_serial_a_data_in,
    output logic                           o_serial_a_clock_in
);

    // selects the peripheral value when the select bit is set
    function automatic logic pick(input logic sel, input logic alt, input logic gen);
        pick = sel ? alt : gen;
    endfunction : pick

    // one address comparison shared by every register decode
    function automatic logic addr_is(input logic [PFM_ADDR_WIDTH-1:0] addr,
                                     input logic [PFM_ADDR_WIDTH-1:0] target);
        addr_is = (addr == target);
    endfunction : addr_is

    // software registers
    logic [7:0] pin_output_data_reg;
    logic [7:0] pin_direction_ctrl_reg;
    logic [7:0] pin_pullup_enable_reg;
    logic [7:0] pin_function_select_reg;
    logic [7:0] rd_data_reg;

    // pad and peripheral registers
    logic [7:0] pad_out_reg;
    logic [7:0] pad_oe_n_reg;
    logic [7:0] pad_pullup_reg;
    logic       chip_select_n_reg;
    logic       serial_b_data_in_reg;
    logic       serial_b_clock_in_reg;
    logic       serial_a_data_in_reg;
    logic       serial_a_clock_in_reg;

    // next values and decodes
    logic [7:0] pin_level;
    logic       hit_data;
    logic       hit_direction;
    logic       hit_pullup;
    logic       hit_function;
    logic [7:0] port_read;
    logic [7:0] rd_data_next;
    logic [7:0] pad_out_next;
    logic [7:0] pad_oe_next;
    logic [7:0] pad_pullup_next;
    logic [7:0] fsel;
    logic [7:0] dir;
    logic       serial_b_clk_is_input;
    logic       serial_a_clk_is_input;
    logic       wr_data_en;
    logic       wr_direction_en;
    logic       wr_pullup_en;
    logic       wr_function_en;
    logic       chip_select_n_next;
    logic       serial_b_data_in_next;
    logic       serial_b_clock_in_next;
    logic       serial_a_data_in_next;
    logic       serial_a_clock_in_next;

    // pin inputs cross from outside through the synchroniser
    pfm_pin_sync #(
        .WIDTH (8)
    ) u_pin_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_pin   (i_pad_in),
        .o_level (pin_level)
    );

    // address decode
    assign hit_data      = addr_is(i_addr, PFM_ADDR_DATA);
    assign hit_direction = addr_is(i_addr, PFM_ADDR_DIRECTION);
    assign hit_pullup    = addr_is(i_addr, PFM_ADDR_PULLUP);
    assign hit_function  = addr_is(i_addr, PFM_ADDR_FUNCTION);

    assign fsel = pin_function_select_reg;
    assign dir  = pin_direction_ctrl_reg;

    // output pins read stored data, input pins read the live level
    assign port_read = (dir & pin_output_data_reg) | (~dir & pin_level);

    // read mux; direction is write-only and reads as ones
    assign rd_data_next = !i_rd_en      ? PFM_RD_UNMAPPED          :
                          hit_data      ? port_read                :
                          hit_direction ? PFM_RD_DIRECTION         :
                          hit_pullup    ? pin_pullup_enable_reg    :
                          hit_function  ? pin_function_select_reg  :
                                          PFM_RD_UNMAPPED;

    // clock pin directions of the two serial channels
    assign serial_b_clk_is_input = (i_serial_b_clock_select == PFM_CLKSEL_EXTERNAL);
    assign serial_a_clk_is_input = i_serial_a_clock_source;

    // per-pin output enable: peripheral direction when selected, else direction bit
    assign pad_oe_next[PFM_PIN_CHIP_SEL]     = pick(fsel[7], 1'b0,
                                                    dir[7]);
    assign pad_oe_next[PFM_PIN_STROBE]       = pick(fsel[6], 1'b1,
                                                    dir[6]);
    assign pad_oe_next[PFM_PIN_SERIAL_B_DO]  = pick(fsel[5], 1'b1,
                                                    dir[5]);
    assign pad_oe_next[PFM_PIN_SERIAL_B_DI]  = pick(fsel[4], 1'b0,
                                                    dir[4]);
    assign pad_oe_next[PFM_PIN_SERIAL_B_CLK] = pick(fsel[3], ~serial_b_clk_is_input,
                                                    dir[3]);
    assign pad_oe_next[PFM_PIN_SERIAL_A_DO]  = pick(fsel[2], 1'b1,
                                                    dir[2]);
    assign pad_oe_next[PFM_PIN_SERIAL_A_DI]  = pick(fsel[1], 1'b0,
                                                    dir[1]);
    assign pad_oe_next[PFM_PIN_SERIAL_A_CLK] = pick(fsel[0], ~serial_a_clk_is_input,
                                                    dir[0]);

    // per-pin output value: peripheral signal when selected, else stored data
    assign pad_out_next[PFM_PIN_CHIP_SEL]     = pick(fsel[7], 1'b0,
                                                     pin_output_data_reg[7]);
    assign pad_out_next[PFM_PIN_STROBE]       = pick(fsel[6], i_strobe_out,
                                                     pin_output_data_reg[6]);
    assign pad_out_next[PFM_PIN_SERIAL_B_DO]  = pick(fsel[5], i_serial_b_data_out,
                                                     pin_output_data_reg[5]);
    assign pad_out_next[PFM_PIN_SERIAL_B_DI]  = pick(fsel[4], 1'b0,
                                                     pin_output_data_reg[4]);
    assign pad_out_next[PFM_PIN_SERIAL_B_CLK] = pick(fsel[3], i_serial_b_clock_out,
                                                     pin_output_data_reg[3]);
    assign pad_out_next[PFM_PIN_SERIAL_A_DO]  = pick(fsel[2], i_serial_a_data_out,
                                                     pin_output_data_reg[2]);
    assign pad_out_next[PFM_PIN_SERIAL_A_DI]  = pick(fsel[1], 1'b0,
                                                     pin_output_data_reg[1]);
    assign pad_out_next[PFM_PIN_SERIAL_A_CLK] = pick(fsel[0], i_serial_a_clock_out,
                                                     pin_output_data_reg[0]);

    // pull-up follows the direction bit alone, whatever the function select
    assign pad_pullup_next = ~dir & pin_pullup_enable_reg;

    // write enables; a strobe to an unmapped address touches nothing
    assign wr_data_en      = i_wr_en & hit_data;
    assign wr_direction_en = i_wr_en & hit_direction;
    assign wr_pullup_en    = i_wr_en & hit_pullup;
    assign wr_function_en  = i_wr_en & hit_function;

    // stored data stays put while a pin is remapped
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            pin_output_data_reg <= PFM_RST_DATA;
        else if (wr_data_en)
            pin_output_data_reg <= i_wr_data;
    end

    // direction is kept too, so a pin returns to general I/O as it was left
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            pin_direction_ctrl_reg <= PFM_RST_DIRECTION;
        else if (wr_direction_en)
            pin_direction_ctrl_reg <= i_wr_data;
    end

    // pull-up enables
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            pin_pullup_enable_reg <= PFM_RST_PULLUP;
        else if (wr_pullup_en)
            pin_pullup_enable_reg <= i_wr_data;
    end

    // function select
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            pin_function_select_reg <= PFM_RST_FUNCTION;
        else if (wr_function_en)
            pin_function_select_reg <= i_wr_data;
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            rd_data_reg <= PFM_RD_UNMAPPED;
        else
            rd_data_reg <= rd_data_next;
    end

    // pad drive is registered so every pad output leaves a flip-flop; costs one cycle
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            pad_out_reg <= 8'h00;
        else
            pad_out_reg <= pad_out_next;
    end

    // pads leave reset as inputs, so nothing is driven before software decides
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            pad_oe_n_reg <= 8'hFF;
        else
            pad_oe_n_reg <= ~pad_oe_next;
    end

    // pull-ups stay off through reset
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            pad_pullup_reg <= 8'h00;
        else
            pad_pullup_reg <= pad_pullup_next;
    end

    // peripheral inputs idle high while their pin serves general I/O,
    // so an unselected chip select never reads as active
    assign chip_select_n_next     = pick(fsel[7], pin_level[7], 1'b1);
    assign serial_b_data_in_next  = pick(fsel[4], pin_level[4], 1'b1);
    assign serial_b_clock_in_next = pick(fsel[3], pin_level[3], 1'b1);
    assign serial_a_data_in_next  = pick(fsel[1], pin_level[1], 1'b1);
    assign serial_a_clock_in_next = pick(fsel[0], pin_level[0], 1'b1);

    // filtered levels lag the pad by a few edges; peripherals see that delay too
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            chip_select_n_reg     <= 1'b1;
            serial_b_data_in_reg  <= 1'b1;
            serial_b_clock_in_reg <= 1'b1;
            serial_a_data_in_reg  <= 1'b1;
            serial_a_clock_in_reg <= 1'b1;
        end
        else
        begin
            chip_select_n_reg     <= chip_select_n_next;
            serial_b_data_in_reg  <= serial_b_data_in_next;
            serial_b_clock_in_reg <= serial_b_clock_in_next;
            serial_a_data_in_reg  <= serial_a_data_in_next;
            serial_a_clock_in_reg <= serial_a_clock_in_next;
        end
    end

    // outputs
    assign o_rd_data           = rd_data_reg;
    assign o_pad_out           = pad_out_reg;
    assign o_pad_oe_n          = pad_oe_n_reg;
    assign o_pad_pullup        = pad_pullup_reg;
    assign o_chip_select_n     = chip_select_n_reg;
    assign o_serial_b_data_in  = serial_b_data_in_reg;
    assign o_serial_b_clock_in = serial_b_clock_in_reg;
    assign o_serial_a_data_in  = serial_a_data_in_reg;
    assign o_serial_a_clock_in = serial_a_clock_in_reg;

endmodule : pfm_pin_function_mux

// ===== verif/pfm_pin_function_mux_chk.sv
// checker: port-level relations of the pin function mux
`timescale 1ns/1ps

module pfm_pin_function_mux_chk
    import pfm_pkg::*;
(
    // clock, reset and register port
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic [15:0] i_addr,
    input  wire logic [7:0]  i_wr_data,
    input  wire logic        i_wr_en,
    input  wire logic        i_rd_en,
    input  wire logic [7:0]  o_rd_data,
    // pads and functions
    input  wire logic [7:0]  o_pad_out,
    input  wire logic [7:0]  o_pad_oe_n,
    input  wire logic [7:0]  o_pad_pullup,
    input  wire logic [2:0]  i_serial_b_clock_select,
    input  wire logic        i_serial_a_clock_source,
    input  wire logic        i_strobe_out,
    input  wire logic        i_serial_b_data_out,
    input  wire logic        i_serial_a_data_out
);
    // shadow of the written registers, so pad outputs can be tied to bus writes
    logic [7:0] fs_reg;
    logic [7:0] dr_reg;
    logic [7:0] pu_reg;
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            fs_reg <= 8'h00;
            dr_reg <= 8'h00;
            pu_reg <= 8'h00;
        end
        else if (i_wr_en)
        begin
            if (i_addr == PFM_ADDR_FUNCTION) fs_reg <= i_wr_data;
            if (i_addr == PFM_ADDR_DIRECTION) dr_reg <= i_wr_data;
            if (i_addr == PFM_ADDR_PULLUP) pu_reg <= i_wr_data;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    pullup_follow_a: assert property (o_pad_pullup == ($past(pu_reg) & ~$past(dr_reg)))
        else $error("pad pull-up differs from pull-up and direction");
    gpio_dir_a: assert property (((o_pad_oe_n ^ ~$past(dr_reg)) & ~$past(fs_reg)) == 8'h00)
        else $error("general pin drive differs from direction");
    cs_input_a: assert property ($past(fs_reg[7]) |-> o_pad_oe_n[7])
        else $error("chip select pin is driven");
    strobe_drive_a: assert property ($past(fs_reg[6]) |->
        !o_pad_oe_n[6] && o_pad_out[6] == $past(i_strobe_out))
        else $error("strobe pin not driven by strobe");
    serial_b_out_a: assert property ($past(fs_reg[5]) |->
        !o_pad_oe_n[5] && o_pad_out[5] == $past(i_serial_b_data_out))
        else $error("serial b data pin wrong");
    serial_a_out_a: assert property ($past(fs_reg[2]) |->
        !o_pad_oe_n[2] && o_pad_out[2] == $past(i_serial_a_data_out))
        else $error("serial a data pin wrong");
    clock_b_dir_a: assert property ($past(fs_reg[3]) |->
        o_pad_oe_n[3] == ($past(i_serial_b_clock_select) == PFM_CLKSEL_EXTERNAL))
        else $error("serial b clock direction wrong");
    clock_a_dir_a: assert property ($past(fs_reg[0]) |->
        o_pad_oe_n[0] == $past(i_serial_a_clock_source))
        else $error("serial a clock direction wrong");
    fsel_read_a: assert property ($past(i_rd_en) && $past(i_addr) == PFM_ADDR_FUNCTION
        |-> o_rd_data == $past(fs_reg))
        else $error("select register read wrong");
    pull_read_a: assert property ($past(i_rd_en) && $past(i_addr) == PFM_ADDR_PULLUP
        |-> o_rd_data == $past(pu_reg))
        else $error("pull-up register read wrong");
    dir_read_a: assert property ($past(i_rd_en) && $past(i_addr) == PFM_ADDR_DIRECTION
        |-> o_rd_data == PFM_RD_DIRECTION)
        else $error("direction read not all ones");
endmodule : pfm_pin_function_mux_chk

bind pfm_pin_function_mux pfm_pin_function_mux_chk u_pfm_pin_function_mux_chk (.*);

// ===== verif/pfm_pad_model.sv
// partner model: external pad network with driver, pull-up and floating level
`timescale 1ns/1ps

module pfm_pad_model
(
    input  wire logic       i_clk,
    input  wire logic [7:0] i_pad_out,
    input  wire logic [7:0] i_pad_oe_n,
    input  wire logic [7:0] i_pad_pullup,
    input  wire logic [7:0] i_ext_val,
    input  wire logic [7:0] i_ext_en,
    output logic      [7:0] o_level
);
    // a floating pin toggles so a settled guess of the simulator never passes
    logic [7:0] flt_reg = 8'h55;
    always_ff @(posedge i_clk) flt_reg <= ~flt_reg;
    assign o_level = (~i_pad_oe_n & i_pad_out) | (i_pad_oe_n & i_ext_en & i_ext_val)
                   | (i_pad_oe_n & ~i_ext_en & (i_pad_pullup | flt_reg));
endmodule : pfm_pad_model

// ===== verif/pfm_pin_function_mux_tb_top.sv
// testbench: random and corner checks of the pin function mux
`timescale 1ns/1ps

module pfm_pin_function_mux_tb_top;
    import pfm_pkg::*;
    logic        i_clk = 0, i_rst_n = 0, i_wr_en = 0, i_rd_en = 0;
    logic [15:0] i_addr = 16'h0000;
    logic [7:0]  i_wr_data = 8'h00, o_rd_data, i_pad_in, o_pad_out, o_pad_oe_n, o_pad_pullup;
    logic [2:0]  i_serial_b_clock_select = 3'h0;
    logic        i_serial_a_clock_source = 0, i_strobe_out = 0, i_serial_b_data_out = 0;
    logic        i_serial_b_clock_out = 0, i_serial_a_data_out = 0, i_serial_a_clock_out = 0;
    logic        o_chip_select_n, o_serial_b_data_in, o_serial_b_clock_in;
    logic        o_serial_a_data_in, o_serial_a_clock_in;
    logic [7:0]  ext_val = 8'h00, ext_en = 8'hFF, f, d, q, p, e, v, lv;
    logic [15:0] x;
    logic [31:0] r, seed = 32'h3;
    int          fail_count = 0, n_tests = 0;
    always #12.5 i_clk = ~i_clk;
    pfm_pin_function_mux u_pfm_pin_function_mux (.*);
    pfm_pad_model u_pfm_pad_model (.i_clk(i_clk), .i_pad_out(o_pad_out),
        .i_pad_oe_n(o_pad_oe_n), .i_pad_pullup(o_pad_pullup), .i_ext_val(ext_val),
        .i_ext_en(ext_en), .o_level(i_pad_in));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // expected {oe_n, out}; c is {a source, b select, strobe, b data, b clock, a data, a clock}
    function automatic logic [15:0] exp_pad(logic [7:0] f, d, q, logic [8:0] c);
        logic [7:0] oe;
        logic [7:0] o;
        oe = (~d & ~f) | (f & {3'b100, 1'b1, c[7:5] == 3'h7, 2'b01, c[8]});
        o  = (q & ~f) | (f & {1'b0, c[4:3], 1'b0, c[2:1], 1'b0, c[0]});
        return {oe, o};
    endfunction : exp_pad
    task automatic wr(input logic [15:0] a, input logic [7:0] dv);
        @(posedge i_clk);
        i_wr_en <= 1;
        i_addr <= a;
        i_wr_data <= dv;
        @(posedge i_clk);
        i_wr_en <= 0;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [7:0] dv);
        @(posedge i_clk);
        i_rd_en <= 1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd_en <= 0;
        @(negedge i_clk);
        dv = o_rd_data;
    endtask : rd
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] ex);
        n_tests++;
        if (s !== ex)
        begin
            $display("mismatch %s expected %h seen %h", n, ex, s);
            fail_count++;
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    initial
    begin
        repeat (20000) @(posedge i_clk);
        fail_count++;
        report_and_stop();
    end
    initial
    begin
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1;
        for (int k = 0; k < 24; k++)
        begin
            f = 8'(xs());
            d = 8'(xs());
            q = 8'(xs());
            p = 8'(xs());
            e = 8'(xs());
            r = xs();
            if (k < 2) f = 8'hFF;
            if (k == 0) r = 32'h1FF;
            if (k == 1) r = 32'h0;
            @(posedge i_clk);
            {i_strobe_out, i_serial_b_data_out, i_serial_b_clock_out} <= r[4:2];
            {i_serial_a_data_out, i_serial_a_clock_out} <= r[1:0];
            i_serial_b_clock_select <= r[7:5];
            i_serial_a_clock_source <= r[8];
            ext_val <= e;
            ext_en <= ~(p & ~d);
            wr(PFM_ADDR_FUNCTION, f);
            wr(PFM_ADDR_DIRECTION, d);
            wr(PFM_ADDR_DATA, q);
            wr(PFM_ADDR_PULLUP, p);
            wr(16'h0000, 8'hA5);
            repeat (6) @(posedge i_clk);
            @(negedge i_clk);
            x = exp_pad(f, d, q, r[8:0]);
            lv = (~x[15:8] & x[7:0]) | (x[15:8] & ((p & ~d) | e));
            chk("pad pullup", o_pad_pullup, p & ~d);
            chk("pad oe_n", o_pad_oe_n, x[15:8]);
            chk("pad out", o_pad_out & ~x[15:8], x[7:0] & ~x[15:8]);
            chk("fn inputs", {3'b000, o_chip_select_n, o_serial_b_data_in, o_serial_b_clock_in,
                o_serial_a_data_in, o_serial_a_clock_in}, {3'b000, {lv[7], lv[4:3], lv[1:0]}
                | ~{f[7], f[4:3], f[1:0]}});
            rd(PFM_ADDR_FUNCTION, v);
            chk("select reg", v, f);
            rd(PFM_ADDR_PULLUP, v);
            chk("pullup reg", v, p);
            rd(PFM_ADDR_DIRECTION, v);
            chk("direction read", v, 8'hFF);
            rd(PFM_ADDR_DATA, v);
            chk("port read", v, (d & q) | (~d & lv));
            rd(16'h0000, v);
            chk("unmapped read", v, PFM_RD_UNMAPPED);
        end
        $display("test random pin functions done");
        @(posedge i_clk);
        i_rst_n <= 0;
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1;
        rd(PFM_ADDR_FUNCTION, v);
        chk("select after reset", v, 8'h00);
        rd(PFM_ADDR_PULLUP, v);
        chk("pullup after reset", v, 8'h00);
        chk("oe_n after reset", o_pad_oe_n, 8'hFF);
        $display("test reset done");
        report_and_stop();
    end
endmodule : pfm_pin_function_mux_tb_top
